// file: common/lp_odt_pkg.sv
package lp_odt_pkg;

  // bus map, byte addresses of 32-bit words
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] REFCNT_ADDR = 4'h8;

  // control word fields
  localparam int CTRL_DLL_DIS   = 0;  // mode reg 1 bit a0
  localparam int CTRL_PD_FAST   = 1;  // mode reg 0 bit a12
  localparam int CTRL_RTT_LO    = 2;  // mode reg 1 a2,a6,a9 and mode reg 2 a9,a10
  localparam int CTRL_RTT_HI    = 6;
  localparam int CTRL_CWL_LO    = 8;
  localparam int CTRL_AL_LO     = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0500;  // cwl 5, al 0

  // status word fields
  localparam int STAT_DLL_ON    = 4;
  localparam int STAT_DLL_LOCK  = 5;
  localparam int STAT_RTT_ON    = 6;
  localparam int STAT_PD_ACTIVE = 7;
  localparam int STAT_CMD_RX    = 8;
  localparam int STAT_PD_SET    = 9;

  // timing, counted on the sampled link clock unless noted
  localparam logic [9:0] DLL_LOCK_CK  = 10'd512;
  localparam logic [3:0] CPDED_CK     = 4'h1;
  localparam int         CLK_NS       = 100;
  localparam int         SR_REF_NS    = 7800;
  localparam logic [7:0] SR_REF_CYC   = 8'(SR_REF_NS / CLK_NS);
  localparam int         ODT_PIPE     = 32;

  typedef enum logic [3:0] {
    st_reset = 4'b0001,
    st_idle  = 4'b0010,
    st_pd    = 4'b0100,
    st_sr    = 4'b1000
  } lp_state_type;

endpackage : lp_odt_pkg

// file: verif/lp_odt_ctrl_bench.sv
`timescale 1ns/1ps
// bench: bus reads queue their expectation, a monitor compares them
module lp_odt_ctrl_bench;
  import lp_odt_pkg::*;
  localparam logic [5:0] NOP = 6'h2e;  // cke high, nop, odt low
  localparam logic [5:0] PDE = 6'h0e;  // cke low, nop
  localparam logic [5:0] SRE = 6'h02;  // cke low, cs ras cas low
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [3:0]  adr_i, sel_i;
  logic [31:0] dat_i, dat_o;
  logic        ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i;
  logic        reset_n_i, banks_open_i, busy_i, rtt_on_o, dll_on_o;
  logic        dll_reset_o, refresh_o, int_clk_en_o, cmd_rx_en_o;
  logic        self_refresh_o, power_down_o, in_reset_o;
  logic [63:0] exp_q[$];
  logic [63:0] ent;
  logic [15:0] ctl;
  int          n_errors, samples_checked, n_dllrst, n_ref;
  int          i, j, odtl;

  lp_odt_ctrl #(.DLL_LOCK(10'd8)) dut (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .ck_i, .cke_i,
    .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .odt_i, .reset_n_i,
    .banks_open_i, .busy_i, .rtt_on_o, .dll_on_o, .dll_reset_o,
    .refresh_o, .int_clk_en_o, .cmd_rx_en_o, .self_refresh_o,
    .power_down_o, .in_reset_o);

  mem_ctrl_model m (.clk_i, .ck_o(ck_i), .cke_o(cke_i), .cs_n_o(cs_n_i),
    .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
    .odt_o(odt_i), .reset_n_o(reset_n_i));

  //////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // one classic cycle; waits on ack, never on a cycle count
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [63:0] em);
    if (!w) begin
      exp_q.push_back(em);
    end
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  // read data is looked at in the one cycle that ack stands
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      ent = exp_q.pop_front();
      chk(dat_o & ent[63:32], ent[31:0]);
    end
  end

  // dll reset pulses are counted, the sequence judges the total
  always @(posedge clk_i) begin
    if (dll_reset_o === 1'b1) n_dllrst++;
    if (refresh_o === 1'b1) n_ref++;
  end

  task automatic complete_run();
    $display("n_errors=%0d samples_checked=%0d", n_errors,
             samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // hang guard, over ten times the expected run length
  initial begin
    #2000000;
    n_errors++;
    complete_run();
  end

  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, banks_open_i, busy_i} = 5'h00;
    adr_i = 4'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    void'($urandom(3988));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values, unmapped place, then idle with dll locked
    wb(0, CTRL_ADDR, 0, {32'hffffffff, 32'h00000500});
    wb(1, 4'hc, 32'hffffffff, 0);
    wb(0, 4'hc, 0, {32'hffffffff, 32'h0});
    wb(0, CTRL_ADDR, 0, {32'hffffffff, 32'h00000500});
    repeat (12) @(posedge ck_i);
    wb(0, STATUS_ADDR, 0, {32'h1ff, 32'h132});
    // termination: disabled by zero bits, else odt after latency
    for (i = 0; i < 2; i++) begin
      ctl = {4'($urandom_range(2, 0)), 4'($urandom_range(8, 5)), 8'h0};
      if (i == 1) ctl[6:2] = 5'($urandom_range(31, 1));
      odtl = int'(ctl[15:12]) + int'(ctl[11:8]) - 2;
      wb(1, CTRL_ADDR, {16'h0, ctl}, 0);
      m.cmd(NOP | 6'h01);
      repeat (odtl - 1) @(posedge ck_i);
      repeat (6) @(posedge clk_i);
      wb(0, STATUS_ADDR, 0, {32'h40, 32'h0});
      @(posedge ck_i);
      repeat (6) @(posedge clk_i);
      wb(0, STATUS_ADDR, 0, {32'h40, 32'(i) << 6});
      m.cmd(NOP);
      repeat (odtl + 1) @(posedge ck_i);
    end
    wb(0, STATUS_ADDR, 0, {32'h40, 32'h0});
    // power-down: precharge slow, active, precharge fast
    for (j = 0; j < 3; j++) begin
      wb(1, CTRL_ADDR, {16'h0, ctl | 16'(j == 2) << 1}, 0);
      banks_open_i <= (j == 1);
      busy_i <= 1'b1;
      m.cmd(PDE);
      repeat (3) @(posedge ck_i);
      wb(0, STATUS_ADDR, 0, {32'h20f, 32'h004});
      busy_i <= 1'b0;
      repeat (3) @(posedge ck_i);
      wb(0, STATUS_ADDR, 0, {32'h3df, 22'h0, 2'b10, 1'(j == 1), 2'b0,
         1'(j != 0), 4'h4});
      chk({30'h0, power_down_o, cmd_rx_en_o}, 32'h2);
      if (j == 1) begin
        m.set_reset(1'b0);
        repeat (8) @(posedge clk_i);
        wb(0, STATUS_ADDR, 0, {32'hf, 32'h1});
        chk({31'h0, in_reset_o}, 32'h1);
        m.set_reset(1'b1);
      end
      m.cmd(NOP);
      repeat (3) @(posedge ck_i);
      wb(0, STATUS_ADDR, 0, {32'hf, 32'h2});
      repeat (10) @(posedge ck_i);
    end
    // self-refresh: entry, pins ignored, internal refresh, exit
    @(posedge clk_i);
    banks_open_i <= 1'b0;
    m.cmd(SRE);
    repeat (6) @(posedge clk_i);
    chk({31'h0, int_clk_en_o}, 32'h0);
    wb(0, STATUS_ADDR, 0, {32'h5f, 32'h008});
    wb(0, REFCNT_ADDR, 0, {32'hffff, 32'h1});
    chk(32'(n_ref), 32'h1);
    chk({27'h0, self_refresh_o, power_down_o, in_reset_o, dll_on_o,
         rtt_on_o}, 32'h10);
    for (i = 0; i < 3; i++) begin
      m.cmd({1'b0, 5'($urandom)});
      wb(0, STATUS_ADDR, 0, {32'h4f, 32'h008});
    end
    m.cmd(NOP);
    // the pulse lands on the sixth clk; count it before looking
    repeat (8) @(posedge clk_i);
    chk(32'(n_dllrst), 32'h1);
    wb(0, STATUS_ADDR, 0, {32'hf, 32'h2});
    repeat (12) @(posedge ck_i);
    wb(0, STATUS_ADDR, 0, {32'h3f, 32'h32});
    // dll-off mode: odt held low, termination bits left set
    wb(1, CTRL_ADDR, {16'h0, ctl | 16'h0001}, 0);
    m.cmd(NOP);
    repeat (4) @(posedge ck_i);
    wb(0, STATUS_ADDR, 0, {32'h7f, 32'h2});
    chk({30'h0, dll_on_o, rtt_on_o}, 32'h0);
    repeat (2) @(posedge clk_i);
    complete_run();
  end
endmodule : lp_odt_ctrl_bench

// file: verif/mem_ctrl_model.sv
`timescale 1ns/1ps
// far-side controller: memory clock, command pins, odt and reset pin
module mem_ctrl_model (
  input  wire logic clk_i,
  output logic      ck_o,
  output logic      cke_o,
  output logic      cs_n_o,
  output logic      ras_n_o,
  output logic      cas_n_o,
  output logic      we_n_o,
  output logic      odt_o,
  output logic      reset_n_o
);
  //////////////////////////////////////////////////////////////////////
  // free-running clock, odd phase so it never lines up with clk_i
  initial begin
    ck_o = 1'b0;
    #137;
    forever #400 ck_o = ~ck_o;
  end

  // deselect with cke high until the bench asks for more
  initial begin
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, odt_o} = 6'h3e;
    reset_n_o = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////
  // pins move half a ck period early so the next ck rise takes them
  task automatic cmd(input logic [5:0] p);
    @(negedge ck_o);
    @(posedge clk_i);
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, odt_o} <= p;
    @(posedge ck_o);
  endtask : cmd

  // reset pin, moved on a clk edge like every other pin
  task automatic set_reset(input logic v);
    @(posedge clk_i);
    reset_n_o <= v;
  endtask : set_reset
endmodule : mem_ctrl_model

// file: verilog/lp_odt_ctrl.sv
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - cs ras cas cke low, we high: self-refresh
// - dll off in self-refresh, reset on exit
// - self-refresh ignores all but cke, reset; clock gated
// - internal refresh soon after self-refresh entry
// - banks closed: precharge, else active power-down
// - power-down stops command receivers after tcpded
// - precharge power-down keeps dll only if a12
// - reset low in power-down enters reset state
// - mode bits enable termination; odt pin decides
// - odt latency is cwl plus al minus 2
module lp_odt_ctrl
  import lp_odt_pkg::*;
#(
  parameter logic [9:0] DLL_LOCK = lp_odt_pkg::DLL_LOCK_CK
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // memory pins, link clock sampled like any pin
  input  wire logic        ck_i,
  input  wire logic        cke_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic        odt_i,
  input  wire logic        reset_n_i,
  // rest of the device
  input  wire logic        banks_open_i,
  input  wire logic        busy_i,
  output logic             rtt_on_o,
  output logic             dll_on_o,
  output logic             dll_reset_o,
  output logic             refresh_o,
  output logic             int_clk_en_o,
  output logic             cmd_rx_en_o,
  output logic             self_refresh_o,
  output logic             power_down_o,
  output logic             in_reset_o
);
  import lp_odt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [7:0]      pins;
  logic            ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s;
  logic            reset_n_s;
  logic            ck_prev;
  logic            ck_rise;
  logic            cke_prev;
  logic            nop_des;
  logic            sre_cmd;

  pin_sync3 #(.WIDTH(8)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({ck_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i,
               reset_n_i}),
    .init_i  (8'h7d),  // idle pin levels: odt low, reset pin high
    .level_o (pins)
  );
  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s,
          reset_n_s} = pins;

  // rising ck is where the memory registers its inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_prev  <= 1'b0;
      cke_prev <= 1'b0;
    end else begin
      ck_prev <= ck_s;
      if (ck_rise) begin
        cke_prev <= cke_s;
      end
    end
  end
  assign ck_rise = ck_s & ~ck_prev;
  assign nop_des = cs_n_s | (ras_n_s & cas_n_s & we_n_s);
  assign sre_cmd = cke_prev & ~cke_s & ~cs_n_s & ~ras_n_s & ~cas_n_s
                   & we_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0]     ctrl;
  logic [15:0]     ref_count;
  logic [31:0]     status;
  logic            dll_dis, pd_fast, term_en;
  logic [3:0]      cwl, al;

  assign dll_dis = ctrl[CTRL_DLL_DIS];
  assign pd_fast = ctrl[CTRL_PD_FAST];
  assign term_en = |ctrl[CTRL_RTT_HI:CTRL_RTT_LO];
  assign cwl     = ctrl[CTRL_CWL_LO +: 4];
  assign al      = ctrl[CTRL_AL_LO +: 4];

  // one wait state; byte lanes honoured on the control word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      ctrl  <= CTRL_RESET;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      if (cyc_i && stb_i && !ack_o && we_i && adr_i == CTRL_ADDR) begin
        if (sel_i[0]) ctrl[7:0]  <= dat_i[7:0];
        if (sel_i[1]) ctrl[15:8] <= dat_i[15:8];
      end
    end
  end

  // read data from flops; unmapped words read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (cyc_i && stb_i && !ack_o) begin
      unique case (adr_i)
        CTRL_ADDR:   dat_o <= {16'h0, ctrl};
        STATUS_ADDR: dat_o <= status;
        REFCNT_ADDR: dat_o <= {16'h0, ref_count};
        default:     dat_o <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state
  lp_state_type    state;
  logic            pd_settled;
  logic            pd_active;
  logic            dll_on;
  logic [9:0]      lock_cnt;
  logic            dll_locked;
  logic [3:0]      cpded_cnt;
  logic [7:0]      ref_timer;

  // reset pin acts on every clk so it works with ck halted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_reset;
    end else if (!reset_n_s) begin
      state <= st_reset;
    end else begin
      unique case (state)
        st_reset: state <= st_idle;
        st_idle: begin
          if (ck_rise && sre_cmd) begin
            state <= st_sr;
          end else if (ck_rise && cke_prev && !cke_s && nop_des) begin
            state <= st_pd;
          end
        end
        st_pd: begin
          if (ck_rise && cke_s) begin
            state <= st_idle;
          end
        end
        st_sr: begin
          if (ck_rise && cke_s) begin  // only cke is looked at here
            state <= st_idle;
          end
        end
      endcase
    end
  end

  // power-down flavour is fixed once the pending work drains
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_settled <= 1'b0;
      pd_active  <= 1'b0;
    end else if (state != st_pd) begin
      pd_settled <= 1'b0;
      pd_active  <= 1'b0;
    end else if (!pd_settled && !busy_i) begin
      pd_settled <= 1'b1;
      pd_active  <= banks_open_i;
    end
  end

  // command receivers drop tcpded ck edges after entry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpded_cnt   <= CPDED_CK;
      cmd_rx_en_o <= 1'b1;
    end else if (state != st_pd) begin
      cpded_cnt   <= CPDED_CK;
      cmd_rx_en_o <= state != st_sr;
    end else begin
      if (ck_rise && cpded_cnt != 4'h0) begin
        cpded_cnt <= cpded_cnt - 4'h1;
      end
      cmd_rx_en_o <= cpded_cnt != 4'h0;
    end
  end

  // dll follows mode bits and power state; relock counts ck edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dll_on      <= 1'b0;
      lock_cnt    <= DLL_LOCK;
      dll_reset_o <= 1'b0;
    end else begin
      dll_reset_o <= 1'b0;
      if (state == st_reset || state == st_sr || dll_dis) begin
        dll_on   <= 1'b0;
        lock_cnt <= DLL_LOCK;
        if (state == st_sr && ck_rise && cke_s && reset_n_s && !dll_dis) begin
          dll_reset_o <= 1'b1;
        end
      end else if (state == st_pd && pd_settled && !pd_active
                   && !pd_fast) begin
        dll_on   <= 1'b0;
        lock_cnt <= DLL_LOCK;
      end else begin
        dll_on <= 1'b1;
        if (ck_rise && lock_cnt != 10'h0) begin
          lock_cnt <= lock_cnt - 10'h1;
        end
      end
    end
  end
  assign dll_locked = dll_on && lock_cnt == 10'h0;

  // built-in refresh timer on clk, since ck may stand still
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_timer <= 8'h0;
      refresh_o <= 1'b0;
      ref_count <= 16'h0;
    end else if (state != st_sr) begin
      ref_timer <= 8'h0;
      refresh_o <= 1'b0;
    end else begin
      refresh_o <= ref_timer == 8'h0;
      ref_timer <= (ref_timer == SR_REF_CYC - 8'h1) ? 8'h0
                                                    : ref_timer + 8'h1;
      if (ref_timer == 8'h0) begin
        ref_count <= ref_count + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination
  logic [ODT_PIPE-1:0] odt_pipe;
  logic [5:0]          odtl_sum;
  logic [4:0]          odtl;
  logic                sync_mode;
  logic                frozen;

  // posted odt: cwl + al - 2, floored at zero
  assign odtl_sum  = 6'(cwl) + 6'(al);
  assign odtl      = (odtl_sum < 6'd2) ? 5'h0 : 5'(odtl_sum - 6'd2);
  assign sync_mode = dll_locked;
  assign frozen    = state == st_pd && !dll_on && !dll_dis;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      odt_pipe <= '0;
    end else if (ck_rise) begin
      odt_pipe <= {odt_pipe[ODT_PIPE-2:0], odt_s};
    end
  end

  // dll-off mode gives no termination; frozen dll passes odt unposted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rtt_on_o <= 1'b0;
    end else if (!term_en || !reset_n_s || state == st_sr
                 || state == st_reset) begin  // pin reset drops it at once
      rtt_on_o <= 1'b0;
    end else if (sync_mode) begin
      rtt_on_o <= odt_pipe[odtl];
    end else begin
      rtt_on_o <= frozen & odt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state outputs
  assign int_clk_en_o   = state != st_sr;
  assign self_refresh_o = state == st_sr;
  assign power_down_o   = state == st_pd;
  assign in_reset_o     = state == st_reset;
  assign dll_on_o       = dll_on;
  assign status = {22'h0, pd_settled, cmd_rx_en_o, pd_active, rtt_on_o,
                   dll_locked, dll_on, state};

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_sre_decode: assert property ((state == st_idle && reset_n_s && ck_rise
    && sre_cmd) |=> state == st_sr)
    else $error("self-refresh entry not decoded");
  a_sr_dll_off: assert property ($rose(state == st_sr) |=> !dll_on)
    else $error("dll still on in self-refresh");
  a_sr_dll_reset: assert property ((state == st_sr && ck_rise && cke_s
    && reset_n_s && !dll_dis) |=> dll_reset_o && state == st_idle)
    else $error("no dll reset on self-refresh exit");
  a_sr_ignores_pins: assert property ((state == st_sr && !cke_s
    && reset_n_s) |=> state == st_sr && !rtt_on_o && !int_clk_en_o)
    else $error("self-refresh reacted to a pin");
  a_sr_first_ref: assert property ($rose(state == st_sr) |=> refresh_o)
    else $error("no internal refresh after entry");
  a_pd_kind: assert property ((state == st_pd && !pd_settled && !busy_i
    && reset_n_s) |=> pd_settled && pd_active == $past(banks_open_i))
    else $error("wrong power-down flavour");
  a_pd_rx_off: assert property ((state == st_pd && cpded_cnt == 4'h0
    && reset_n_s) |=> !cmd_rx_en_o)
    else $error("command receivers still on");
  a_pd_slow_dll: assert property ((state == st_pd && pd_settled
    && !pd_active && !pd_fast && reset_n_s) |=> !dll_on)
    else $error("dll kept in slow precharge power-down");
  a_pd_reset: assert property ((state == st_pd && !reset_n_s) |=>
    in_reset_o && !rtt_on_o)
    else $error("reset ignored in power-down");
  a_rtt_disabled: assert property ((!term_en || state == st_sr) |=>
    !rtt_on_o)
    else $error("termination on while disabled");
  a_odt_latency: assert property ((sync_mode && term_en && reset_n_s
    && state == st_idle && $past(ck_rise) && $stable(odtl))
    |=> rtt_on_o == $past(odt_pipe[odtl]))
    else $error("odt latency wrong");

  c_sr_round: cover property (state == st_sr ##[1:1000] state == st_idle);
  c_pd_active: cover property (state == st_pd && pd_settled && pd_active);
  c_pd_slow: cover property (state == st_pd && pd_settled && !dll_on);
  c_rtt_on: cover property ($rose(rtt_on_o));

endmodule : lp_odt_ctrl

// file: verilog/pin_sync3.sv
`timescale 1ns/1ps
// three-stage sampler; a bit changes once stages two and three agree
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] init_i,
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only, to keep metastability contained
  always_ff @(posedge clk_i) begin
    stage1 <= pin_i;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // init comes from a constant at the instance
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o <= init_i;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          level_o[i] <= stage3[i];
        end
      end
    end
  end
endmodule : pin_sync3
